// ### include/adcc_pkg.sv
// Constants, register map and types of the converter control block
package adcc_pkg;

   // *****************************************************
   // Register byte offsets
   // *****************************************************
   localparam logic [7:0] ADCC_OFS_CTRL0 = 8'h00;  // Converter control 0
   localparam logic [7:0] ADCC_OFS_CTRL1 = 8'h04;  // Converter control 1
   localparam logic [7:0] ADCC_OFS_INT = 8'h08;    // Interrupt flag and enables
   localparam logic [7:0] ADCC_OFS_RES_H = 8'h0C;  // Result high byte
   localparam logic [7:0] ADCC_OFS_RES_L = 8'h10;  // Result low byte

   // *****************************************************
   // Field positions
   // *****************************************************
   localparam int ADCC_C0_START = 7;    // Start bit
   localparam int ADCC_C0_BUSY = 6;     // Busy flag, read only
   localparam int ADCC_C0_PWR = 5;      // Power enable
   localparam int ADCC_C0_FMT = 4;      // Result format
   localparam int ADCC_C0_CH_LSB = 0;   // External channel, 4 bits
   localparam int ADCC_C1_DIV_LSB = 0;  // Clock divider, 3 bits
   localparam int ADCC_C1_SRC_LSB = 3;  // Input source, 3 bits
   localparam int ADCC_C1_REF_LSB = 6;  // Reference source, 2 bits
   localparam int ADCC_C1_GAIN_LSB = 8; // Amplifier gain, 3 bits
   localparam int ADCC_C1_AIN_LSB = 11; // Amplifier input, 2 bits
   localparam int ADCC_INT_FLAG = 0;    // Interrupt flag
   localparam int ADCC_INT_ADE = 1;     // Converter interrupt enable
   localparam int ADCC_INT_EMI = 2;     // Global interrupt enable

   // *****************************************************
   // Reset values and encodings
   // *****************************************************
   localparam logic [7:0] ADCC_CTRL0_RST = 8'h00;   // Off, channel 0
   localparam logic [12:0] ADCC_CTRL1_RST = 13'h0000; // Divide by 1
   localparam logic [2:0] ADCC_SRC_EXTERNAL = 3'h0; // External channel
   localparam logic [1:0] ADCC_REF_AMP = 2'h1;      // Amplifier output reference

   // *****************************************************
   // Sampling count in conversion clock periods, result width and bus answer codes
   // *****************************************************
   localparam logic [3:0] ADCC_SAMPLE_PERIODS = 4'h4; // Sampling part
   localparam int ADCC_RES_W = 12;                    // Result width
   localparam logic [1:0] ADCC_RESP_OKAY = 2'h0;      // Bus answer ok
   localparam logic [1:0] ADCC_RESP_SLVERR = 2'h2;    // Unmapped address

   // Sequencer states
   typedef enum logic [1:0] {ADCC_IDLE, ADCC_SAMPLE, ADCC_CONVERT} adcc_state_t;

endpackage : adcc_pkg

// ### src/adcc_clkdiv.sv
// Conversion clock divider producing one tick per conversion clock period
`timescale 1ns/1ns
module adcc_clkdiv
(
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RST_N_I,
   // Control
   input wire logic enable_i,
   input wire logic restart_i,
   input wire logic [2:0] div_code_i,
   // Tick out
   output logic tick_o
);

   // *****************************************************
   // State
   // *****************************************************
   typedef struct packed {
      logic [6:0] cnt;   // Cycles in the current period
   } adcc_div_t;

   adcc_div_t cur_ff;    // Registered state
   adcc_div_t nxt_cur;   // Next state
   logic [6:0] last;     // Terminal count

   assign last = 7'((8'h01 << div_code_i) - 8'h01);
   assign tick_o = enable_i && !restart_i && (cur_ff.cnt == last);

   // Next count; restart aligns the first period to the start
   always_comb
   begin
      nxt_cur = cur_ff;
      if (!enable_i || restart_i || (cur_ff.cnt >= last))
      begin
         nxt_cur.cnt = 7'h00;
      end
      else
      begin
         nxt_cur.cnt = 7'(cur_ff.cnt + 7'h01);
      end
   end

   // Register
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         cur_ff <= '0;
      end
      else
      begin
         cur_ff <= nxt_cur;
      end
   end

endmodule : adcc_clkdiv

// ### src/adcc_sar.sv
// Successive approximation sequencer: sampling then twelve bit decisions
`timescale 1ns/1ns
module adcc_sar
(
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RST_N_I,
   // Control
   input wire logic tick_i,
   input wire logic go_i,
   input wire logic abort_i,
   input wire logic cmp_i,
   // Status and data
   output logic sampling_o,
   output logic busy_o,
   output logic done_o,
   output logic [11:0] trial_o,
   output logic [11:0] result_o
);

   // *****************************************************
   // State
   // *****************************************************
   typedef struct packed {
      adcc_pkg::adcc_state_t st; // Sequencer state
      logic [3:0] cnt;           // Sampling periods
      logic [11:0] mask;         // Bit under trial
      logic [11:0] code;         // Trial code to the DAC
      logic [11:0] result;       // Finished value
      logic done;                // Completion pulse
   } adcc_sar_t;

   adcc_sar_t cur_ff;  // Registered state
   adcc_sar_t nxt_cur; // Next state
   logic [11:0] kept;  // Code after this decision

   assign sampling_o = (cur_ff.st == adcc_pkg::ADCC_SAMPLE);
   assign busy_o = (cur_ff.st != adcc_pkg::ADCC_IDLE);
   assign done_o = cur_ff.done;
   assign trial_o = cur_ff.code;
   assign result_o = cur_ff.result;
   // comparator high means input at or above trial
   assign kept = cmp_i ? cur_ff.code : (cur_ff.code & ~cur_ff.mask);

   // Sequencing
   always_comb
   begin
      nxt_cur = cur_ff;
      nxt_cur.done = 1'b0;
      if (abort_i)
      begin
         nxt_cur.st = adcc_pkg::ADCC_IDLE;
      end
      else
      begin
         unique case (cur_ff.st)
            adcc_pkg::ADCC_IDLE:
            begin
               if (go_i)
               begin
                  nxt_cur.st = adcc_pkg::ADCC_SAMPLE;
                  nxt_cur.cnt = 4'h0;
                  nxt_cur.code = 12'h000;
               end
            end
            adcc_pkg::ADCC_SAMPLE:
            begin
               if (tick_i)
               begin
                  nxt_cur.cnt = 4'(cur_ff.cnt + 4'h1);
                  if (cur_ff.cnt == adcc_pkg::ADCC_SAMPLE_PERIODS - 4'h1)
                  begin
                     nxt_cur.st = adcc_pkg::ADCC_CONVERT;
                     nxt_cur.mask = 12'h800;
                     nxt_cur.code = 12'h800;
                  end
               end
            end
            adcc_pkg::ADCC_CONVERT:
            begin
               // one bit per period, twelve periods
               if (tick_i)
               begin
                  if (cur_ff.mask[0])
                  begin
                     nxt_cur.st = adcc_pkg::ADCC_IDLE;
                     nxt_cur.result = kept;
                     nxt_cur.code = kept;
                     nxt_cur.done = 1'b1;
                  end
                  else
                  begin
                     nxt_cur.mask = cur_ff.mask >> 1;
                     nxt_cur.code = kept | (cur_ff.mask >> 1);
                  end
               end
            end
            default:
            begin
               nxt_cur.st = adcc_pkg::ADCC_IDLE;
            end
         endcase
      end
   end

   // Register
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         cur_ff <= '0;
      end
      else
      begin
         cur_ff <= nxt_cur;
      end
   end

endmodule : adcc_sar

// ### src/adcc_top.sv
// Converter control top: register slave, start detection, analog steering
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
module adcc_top
#(
   parameter int ADDR_W = 8 // Bus address width
)
(
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RST_N_I,
   // Write address channel
   input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
   input wire logic [2:0] S_AXI_AWPROT_I,
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   // Write data channel
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic [3:0] S_AXI_WSTRB_I,
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   // Write response channel
   output logic [1:0] S_AXI_BRESP_O,
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   // Read address channel
   input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
   input wire logic [2:0] S_AXI_ARPROT_I,
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   // Read data channel
   output logic [31:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   // Analog front end
   input wire logic ANA_CMP_I,
   output logic ANA_POWER_O,
   output logic ANA_SAMPLE_O,
   output logic ANA_EXT_CONNECT_O,
   output logic [3:0] ANA_EXT_CHAN_O,
   output logic [2:0] ANA_SOURCE_O,
   output logic [1:0] ANA_REF_SEL_O,
   output logic [2:0] ANA_AMP_GAIN_O,
   output logic [1:0] ANA_AMP_IN_O,
   output logic [11:0] ANA_TRIAL_O,
   // Interrupt request
   output logic IRQ_REQ_O
);

   // *****************************************************
   // State
   // *****************************************************
   typedef struct packed {
      logic aw_full;          // Write address held
      logic [ADDR_W-1:0] aw;  // Held write address
      logic w_full;           // Write data held
      logic [31:0] wd;        // Held write data
      logic [3:0] ws;         // Held strobes
      logic bvalid;           // Write answer pending
      logic [1:0] bresp;      // Write answer code
      logic rvalid;           // Read answer pending
      logic [31:0] rdata;     // Read answer data
      logic [1:0] rresp;      // Read answer code
      logic [7:0] ctrl0;      // Control 0 as written
      logic [12:0] ctrl1;     // Control 1
      logic flag;             // Interrupt flag
      logic ade;              // Converter interrupt enable
      logic global_interrupt_enable;              // Global interrupt enable
      logic [7:0] res_h;      // Result high byte
      logic [7:0] res_l;      // Result low byte
      logic start_d;          // Start bit last cycle
      logic [2:0] cmp_sync;   // Comparator synchroniser
      logic cmp;              // Agreed comparator level
   } adcc_top_t;

   adcc_top_t cur_ff;        // Registered state
   adcc_top_t nxt_cur;       // Next state
   logic pwr;                // Converter powered
   logic start_bit;          // Start bit value
   logic go;                 // Start pulse completed
   logic tick;               // Conversion clock period end
   logic busy;               // Conversion in progress
   logic done;               // Conversion finished
   logic sampling;           // Sampling phase
   logic [11:0] result;      // Finished value
   logic [11:0] trial;       // Trial code
   logic do_write;           // Both write halves present
   logic [2:0] src;          // Input source select
   logic [1:0] ref_sel;      // Reference source select
   logic cmp_now;            // Agreed comparator level

   // *****************************************************
   // Conversion engine
   // *****************************************************
   assign pwr = cur_ff.ctrl0[adcc_pkg::ADCC_C0_PWR];
   assign start_bit = cur_ff.ctrl0[adcc_pkg::ADCC_C0_START];
   // falling edge after high ends the pulse
   assign go = pwr && cur_ff.start_d && !start_bit;
   assign src = cur_ff.ctrl1[adcc_pkg::ADCC_C1_SRC_LSB +: 3];
   assign ref_sel = cur_ff.ctrl1[adcc_pkg::ADCC_C1_REF_LSB +: 2];
   // Stages two and three agreeing pass straight on; skipping the held copy
   // saves a cycle per decision, so four-cycle periods see the settled answer
   assign cmp_now = (cur_ff.cmp_sync[2] == cur_ff.cmp_sync[1]) ?
                    cur_ff.cmp_sync[2] : cur_ff.cmp;

   // Divider restarts on the start pulse so sampling gets full periods
   adcc_clkdiv u_div
   (
      .CLK_I(CLK_I),
      .RST_N_I(RST_N_I),
      .enable_i(pwr),
      .restart_i(go),
      .div_code_i(cur_ff.ctrl1[adcc_pkg::ADCC_C1_DIV_LSB +: 3]),
      .tick_o(tick)
   );

   // Power off or a high start bit holds the sequencer idle
   adcc_sar u_sar
   (
      .CLK_I(CLK_I),
      .RST_N_I(RST_N_I),
      .tick_i(tick),
      .go_i(go),
      .abort_i(!pwr || start_bit),
      .cmp_i(cmp_now),
      .sampling_o(sampling),
      .busy_o(busy),
      .done_o(done),
      .trial_o(trial),
      .result_o(result)
   );

   // *****************************************************
   // Analog steering
   // *****************************************************
   // power off gates sampling, the external switch and its channel only
   assign ANA_POWER_O = pwr;
   assign ANA_SAMPLE_O = pwr && sampling;
   assign ANA_TRIAL_O = trial;
   assign ANA_EXT_CONNECT_O = pwr && (src == adcc_pkg::ADCC_SRC_EXTERNAL);
   assign ANA_EXT_CHAN_O = ANA_EXT_CONNECT_O ?
                           cur_ff.ctrl0[adcc_pkg::ADCC_C0_CH_LSB +: 4] : 4'h0;
   assign ANA_SOURCE_O = src;
   // reference select, amplifier only when chosen
   assign ANA_REF_SEL_O = ref_sel;
   assign ANA_AMP_GAIN_O = (ref_sel == adcc_pkg::ADCC_REF_AMP) ?
                           cur_ff.ctrl1[adcc_pkg::ADCC_C1_GAIN_LSB +: 3] : 3'h0;
   assign ANA_AMP_IN_O = (ref_sel == adcc_pkg::ADCC_REF_AMP) ?
                         cur_ff.ctrl1[adcc_pkg::ADCC_C1_AIN_LSB +: 2] : 2'h0;

   // request needs flag and both enables
   assign IRQ_REQ_O = cur_ff.flag && cur_ff.ade && cur_ff.global_interrupt_enable;

   // *****************************************************
   // Bus handshakes
   // *****************************************************
   // Each write half is held until the other arrives
   assign S_AXI_AWREADY_O = !cur_ff.aw_full && !cur_ff.bvalid;
   assign S_AXI_WREADY_O = !cur_ff.w_full && !cur_ff.bvalid;
   assign S_AXI_BVALID_O = cur_ff.bvalid;
   assign S_AXI_BRESP_O = cur_ff.bresp;
   assign S_AXI_ARREADY_O = !cur_ff.rvalid;
   assign S_AXI_RVALID_O = cur_ff.rvalid;
   assign S_AXI_RDATA_O = cur_ff.rdata;
   assign S_AXI_RRESP_O = cur_ff.rresp;
   assign do_write = cur_ff.aw_full && cur_ff.w_full;

   // Next state of bus, registers and result
   always_comb
   begin
      nxt_cur = cur_ff;
      nxt_cur.start_d = start_bit;
      // Only the agreeing later stages decide the level
      nxt_cur.cmp_sync = {cur_ff.cmp_sync[1:0], ANA_CMP_I};
      nxt_cur.cmp = cmp_now;
      // Capture write halves
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
      begin
         nxt_cur.aw_full = 1'b1;
         nxt_cur.aw = S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O)
      begin
         nxt_cur.w_full = 1'b1;
         nxt_cur.wd = S_AXI_WDATA_I;
         nxt_cur.ws = S_AXI_WSTRB_I;
      end
      // Retire write answer
      if (cur_ff.bvalid && S_AXI_BREADY_I)
      begin
         nxt_cur.bvalid = 1'b0;
      end
      // Perform the write once both halves are in
      if (do_write)
      begin
         nxt_cur.aw_full = 1'b0;
         nxt_cur.w_full = 1'b0;
         nxt_cur.bvalid = 1'b1;
         nxt_cur.bresp = adcc_pkg::ADCC_RESP_OKAY;
         unique case (cur_ff.aw)
            adcc_pkg::ADCC_OFS_CTRL0:
            begin
               if (cur_ff.ws[0])
               begin
                  nxt_cur.ctrl0 = cur_ff.wd[7:0];
               end
            end
            adcc_pkg::ADCC_OFS_CTRL1:
            begin
               if (cur_ff.ws[0])
               begin
                  nxt_cur.ctrl1[7:0] = cur_ff.wd[7:0];
               end
               if (cur_ff.ws[1])
               begin
                  nxt_cur.ctrl1[12:8] = cur_ff.wd[12:8];
               end
            end
            adcc_pkg::ADCC_OFS_INT:
            begin
               if (cur_ff.ws[0])
               begin
                  if (!cur_ff.wd[adcc_pkg::ADCC_INT_FLAG])
                  begin
                     nxt_cur.flag = 1'b0;
                  end
                  nxt_cur.ade = cur_ff.wd[adcc_pkg::ADCC_INT_ADE];
                  nxt_cur.global_interrupt_enable = cur_ff.wd[adcc_pkg::ADCC_INT_EMI];
               end
            end
            adcc_pkg::ADCC_OFS_RES_H, adcc_pkg::ADCC_OFS_RES_L:
            begin
               // Result bytes ignore writes
               nxt_cur.bresp = adcc_pkg::ADCC_RESP_OKAY;
            end
            default:
            begin
               nxt_cur.bresp = adcc_pkg::ADCC_RESP_SLVERR;
            end
         endcase
      end
      // Retire read answer
      if (cur_ff.rvalid && S_AXI_RREADY_I)
      begin
         nxt_cur.rvalid = 1'b0;
      end
      // Take a read and register its data
      if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
      begin
         nxt_cur.rvalid = 1'b1;
         nxt_cur.rresp = adcc_pkg::ADCC_RESP_OKAY;
         nxt_cur.rdata = 32'h0000_0000;
         unique case (S_AXI_ARADDR_I)
            adcc_pkg::ADCC_OFS_CTRL0:
            begin
               nxt_cur.rdata[7:0] = cur_ff.ctrl0;
               nxt_cur.rdata[adcc_pkg::ADCC_C0_BUSY] = busy || done;
            end
            adcc_pkg::ADCC_OFS_CTRL1:
            begin
               nxt_cur.rdata[12:0] = cur_ff.ctrl1;
            end
            adcc_pkg::ADCC_OFS_INT:
            begin
               nxt_cur.rdata[adcc_pkg::ADCC_INT_FLAG] = cur_ff.flag;
               nxt_cur.rdata[adcc_pkg::ADCC_INT_ADE] = cur_ff.ade;
               nxt_cur.rdata[adcc_pkg::ADCC_INT_EMI] = cur_ff.global_interrupt_enable;
            end
            adcc_pkg::ADCC_OFS_RES_H:
            begin
               nxt_cur.rdata[7:0] = cur_ff.res_h;
            end
            adcc_pkg::ADCC_OFS_RES_L:
            begin
               nxt_cur.rdata[7:0] = cur_ff.res_l;
            end
            default:
            begin
               nxt_cur.rresp = adcc_pkg::ADCC_RESP_SLVERR;
            end
         endcase
      end
      // result, flag and busy drop share one edge
      if (done)
      begin
         // completion sets the flag, winning a clear
         nxt_cur.flag = 1'b1;
         if (cur_ff.ctrl0[adcc_pkg::ADCC_C0_FMT])
         begin
            nxt_cur.res_h = {4'h0, result[11:8]};
            nxt_cur.res_l = result[7:0];
         end
         else
         begin
            nxt_cur.res_h = result[11:4];
            nxt_cur.res_l = {result[3:0], 4'h0};
         end
      end
   end

   // Register everything; reset takes constants only
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         cur_ff <= '0;
         cur_ff.ctrl0 <= adcc_pkg::ADCC_CTRL0_RST;
         cur_ff.ctrl1 <= adcc_pkg::ADCC_CTRL1_RST;
      end
      else
      begin
         cur_ff <= nxt_cur;
      end
   end

endmodule : adcc_top

// ### bench/adcc_top_asserts.sv
// Port checker for the converter control block
`timescale 1ns/1ns
module adcc_top_asserts
#(
   parameter int ADDR_W = 8 // Kept for the bind
)
(
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RST_N_I,
   // Bus answers
   input wire logic S_AXI_BREADY_I,
   input wire logic S_AXI_RREADY_I,
   input wire logic S_AXI_ARREADY_O,
   input wire logic [1:0] S_AXI_BRESP_O,
   input wire logic S_AXI_BVALID_O,
   input wire logic [31:0] S_AXI_RDATA_O,
   input wire logic S_AXI_RVALID_O,
   // Analog steering
   input wire logic ANA_POWER_O,
   input wire logic ANA_SAMPLE_O,
   input wire logic ANA_EXT_CONNECT_O,
   input wire logic [3:0] ANA_EXT_CHAN_O,
   input wire logic [2:0] ANA_SOURCE_O,
   input wire logic [1:0] ANA_REF_SEL_O,
   input wire logic [2:0] ANA_AMP_GAIN_O,
   input wire logic [1:0] ANA_AMP_IN_O,
   input wire logic IRQ_REQ_O
);
   // One clock domain
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!RST_N_I);
   ext_switch_a:
      assert property (ANA_EXT_CONNECT_O == (ANA_POWER_O && ANA_SOURCE_O == 3'h0))
      else $error("external switch wrong");
   chan_gate_a:
      assert property (!ANA_EXT_CONNECT_O |-> ANA_EXT_CHAN_O == 4'h0)
      else $error("channel not gated");
   amp_gate_a:
      assert property (ANA_REF_SEL_O != 2'h1 |-> {ANA_AMP_GAIN_O, ANA_AMP_IN_O} == 5'h00)
      else $error("amplifier not gated");
   power_off_a:
      assert property (!ANA_POWER_O |-> !ANA_SAMPLE_O)
      else $error("sampling while off");
   sample_len_a:
      assert property ($rose(ANA_SAMPLE_O) |-> ANA_SAMPLE_O [*4])
      else $error("sampling too short");
   resp_hold_a:
      assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
      else $error("write answer dropped");
   resp_done_a:
      assert property (S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O)
      else $error("write answer repeated");
   rdata_hold_a:
      assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> $stable(S_AXI_RDATA_O))
      else $error("read data moved");
   read_gate_a:
      assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
      else $error("read taken while pending");
   // Main scenarios reached
   cover property ($rose(ANA_SAMPLE_O));
   cover property ($rose(IRQ_REQ_O));
   cover property (S_AXI_BVALID_O && S_AXI_BRESP_O == 2'h2);
endmodule : adcc_top_asserts
bind adcc_top adcc_top_asserts #(.ADDR_W(ADDR_W)) chk (.*);

// ### bench/adcc_ana_model.sv
// Analog front end model: input levels and comparator
`timescale 1ns/1ns
module adcc_ana_model
(
   // Clock
   input wire logic clk_i,
   // Steering from the block
   input wire logic power_i,
   input wire logic ext_connect_i,
   input wire logic [3:0] ext_chan_i,
   input wire logic [2:0] source_i,
   input wire logic [11:0] trial_i,
   // Comparator
   output logic cmp_o
);
   logic [11:0] level; // Input in counts of reference over 4096
   logic junk_ff = 1'h0; // Noise while unpowered
   assign level = ext_connect_i ? {ext_chan_i, 8'hA5} : {source_i, 9'h0C3};
   // all ones is full scale, toggling noise when off
   assign cmp_o = power_i ? (level >= trial_i) : junk_ff;
   always @(posedge clk_i) junk_ff <= ~junk_ff;
endmodule : adcc_ana_model

// ### bench/adc_conversion_control_test.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ns
module adc_conversion_control_test;
   logic CLK_I = 1'h0, RST_N_I = 1'h0;
   logic [7:0] S_AXI_AWADDR_I = 8'h00, S_AXI_ARADDR_I = 8'h00;
   logic [31:0] S_AXI_WDATA_I = 32'h0, S_AXI_RDATA_O, rv;
   logic [3:0] S_AXI_WSTRB_I = 4'hF, ANA_EXT_CHAN_O;
   logic [2:0] S_AXI_AWPROT_I = 3'h0, S_AXI_ARPROT_I = 3'h0;
   logic S_AXI_AWVALID_I = 1'h0, S_AXI_WVALID_I = 1'h0, S_AXI_BREADY_I = 1'h0;
   logic S_AXI_ARVALID_I = 1'h0, S_AXI_RREADY_I = 1'h0, ANA_CMP_I;
   logic S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O;
   logic S_AXI_RVALID_O, ANA_POWER_O, ANA_SAMPLE_O, ANA_EXT_CONNECT_O, IRQ_REQ_O;
   logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O, ANA_REF_SEL_O, ANA_AMP_IN_O, rr;
   logic [2:0] ANA_SOURCE_O, ANA_AMP_GAIN_O;
   logic [11:0] ANA_TRIAL_O;
   logic [7:0] last_h = 8'h00; // High byte of last exact result
   logic prev_ok = 1'h0, samp_q = 1'h0;
   int mismatches = 0, compares = 0, samp_n = 0, conv_n = 0;
   adcc_top dut (.*);
   adcc_ana_model ana (.clk_i(CLK_I), .power_i(ANA_POWER_O), .ext_connect_i(ANA_EXT_CONNECT_O),
      .ext_chan_i(ANA_EXT_CHAN_O), .source_i(ANA_SOURCE_O), .trial_i(ANA_TRIAL_O),
      .cmp_o(ANA_CMP_I));
   initial forever #25 CLK_I = ~CLK_I;
   // Length of last sampling run, and cycles from its end to the request
   always @(posedge CLK_I)
   begin
      samp_q <= ANA_SAMPLE_O;
      samp_n <= ANA_SAMPLE_O ? (samp_q ? samp_n + 1 : 1) : samp_n;
      conv_n <= ANA_SAMPLE_O ? 0 : (IRQ_REQ_O ? conv_n : conv_n + 1);
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Bus write; address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      S_AXI_AWADDR_I <= a;
      S_AXI_WDATA_I <= d;
      S_AXI_AWVALID_I <= 1'h1;
      S_AXI_WVALID_I <= 1'h1;
      S_AXI_BREADY_I <= 1'h1;
      do
      begin
         @(posedge CLK_I);
         if (S_AXI_AWREADY_O) S_AXI_AWVALID_I <= 1'h0;
         if (S_AXI_WREADY_O) S_AXI_WVALID_I <= 1'h0;
      end
      while (!S_AXI_BVALID_O);
      rr = S_AXI_BRESP_O;
      S_AXI_BREADY_I <= 1'h0;
      @(posedge CLK_I);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      S_AXI_ARADDR_I <= a;
      S_AXI_ARVALID_I <= 1'h1;
      S_AXI_RREADY_I <= 1'h1;
      do
      begin
         @(posedge CLK_I);
         if (S_AXI_ARREADY_O) S_AXI_ARVALID_I <= 1'h0;
      end
      while (!S_AXI_RVALID_O);
      rv = S_AXI_RDATA_O;
      rr = S_AXI_RRESP_O;
      S_AXI_RREADY_I <= 1'h0;
      @(posedge CLK_I);
   endtask : rd
   // One conversion; divider codes below 2 are timed only
   task automatic conv(input logic [2:0] dv, input logic fm, input logic [3:0] ch,
                       input logic [2:0] sr);
      logic [11:0] e;
      e = (sr == 3'h0) ? {ch, 8'hA5} : {sr, 9'h0C3};
      wr(8'h04, {19'h0, 13'h1540} | {26'h0, sr, dv});
      chk({25'h0, ANA_REF_SEL_O, ANA_AMP_GAIN_O, ANA_AMP_IN_O}, 32'h36);
      wr(8'h08, 32'h6);
      wr(8'h00, {24'h0, 3'h5, fm, ch});
      wr(8'h00, {24'h0, 3'h1, fm, ch});
      chk({27'h0, ANA_EXT_CONNECT_O, ANA_EXT_CHAN_O}, {27'h0, sr == 3'h0, sr == 3'h0 ? ch : 4'h0});
      rd(8'h00);
      chk({31'h0, rv[6]}, 32'h1);
      if (prev_ok) rd(8'h0C);
      if (prev_ok) chk(rv, {24'h0, last_h});
      while (!IRQ_REQ_O) @(posedge CLK_I);
      chk(32'(samp_n), 32'(4 << dv));
      chk(32'(conv_n >= (12 << dv) && conv_n <= (12 << dv) + 2), 32'h1);
      rd(8'h00);
      chk({31'h0, rv[6]}, 32'h0);
      prev_ok = dv > 3'h1;
      last_h = fm ? {4'h0, e[11:8]} : e[11:4];
      if (prev_ok) rd(8'h0C);
      if (prev_ok) chk(rv, {24'h0, last_h});
      if (prev_ok) rd(8'h10);
      if (prev_ok) chk(rv, {24'h0, fm ? e[7:0] : {e[3:0], 4'h0}});
      $display("test conversion done");
   endtask : conv
   task automatic results;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : results
   // Hang guard, well beyond all conversions
   initial
   begin
      repeat (40000) @(posedge CLK_I);
      mismatches++;
      results();
   end
   initial
   begin
      repeat (10) @(posedge CLK_I);
      RST_N_I <= 1'h1;
      @(posedge CLK_I);
      rd(8'h08);
      chk(rv, 32'h0);
      rd(8'h14);
      chk({30'h0, rr}, 32'h2);
      wr(8'h14, 32'h0);
      chk({30'h0, rr}, 32'h2);
      // Start pulse with power off must not sample
      wr(8'h00, 32'h80);
      wr(8'h00, 32'h00);
      repeat (40) @(posedge CLK_I);
      chk(32'(samp_n) | {31'h0, ANA_POWER_O}, 32'h0);
      $display("test power off done");
      for (int i = 0; i < 8; i++) conv(3'(i), 1'(i), 4'(i + 1), 3'h0);
      conv(3'h2, 1'h0, 4'h9, 3'h3);
      // Request gating by the converter enable and the flag
      wr(8'h08, 32'h5);
      chk({31'h0, IRQ_REQ_O}, 32'h0);
      wr(8'h08, 32'h7);
      chk({31'h0, IRQ_REQ_O}, 32'h1);
      wr(8'h08, 32'h6);
      chk({31'h0, IRQ_REQ_O}, 32'h0);
      wr(8'h04, 32'h1580);
      chk({27'h0, ANA_AMP_GAIN_O, ANA_AMP_IN_O}, 32'h0);
      $display("test enables done");
      // Polling with both enables off: flag sets, no request
      wr(8'h08, 32'h0);
      wr(8'h00, 32'hA0);
      wr(8'h00, 32'h20);
      do rd(8'h00); while (rv[6]);
      rd(8'h08);
      chk(rv, 32'h1);
      chk({31'h0, IRQ_REQ_O}, 32'h0);
      $display("test polling done");
      results();
   end
endmodule : adc_conversion_control_test
